// *** rtl/debug_mode_pkg.sv ***
// package: constants and states for the debug mode entry control
package debug_mode_pkg;

  // time the host holds the debug pin low after reset, in cycles
  localparam int unsigned PIN_HOLD_CYCLES = 5000;
  // clock period in ns at 200 MHz
  localparam int unsigned CLK_PERIOD_NS   = 5;
  // width of the post-reset low-level counter
  localparam int unsigned HOLD_CNT_W      = 13;
  // reset value of the mode state
  localparam logic [2:0]  MODE_RESET      = 3'h1;

  typedef enum logic [2:0] {
    MODE_RUN   = 3'h1,
    MODE_DEBUG = 3'h2,
    MODE_EXIT  = 3'h4
  } mode_t;

endpackage : debug_mode_pkg

// *** rtl/pin_low_counter.sv ***
// counts cycles that the debug pin stays low after reset release
`timescale 1ns/100ps
module pin_low_counter #(
  parameter int unsigned HOLD = debug_mode_pkg::PIN_HOLD_CYCLES,
  parameter int unsigned W    = debug_mode_pkg::HOLD_CNT_W
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // pin level and arming
  input  wire logic debug_pin_i,
  input  wire logic arm,
  // result
  output logic      hold_done
);

  logic [W-1:0] cnt_q;
  logic         active_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end else if (arm) begin
      cnt_q    <= '0;
      active_q <= 1'b1;
    end else if (active_q) begin
      if (debug_pin_i) begin
        active_q <= 1'b0;
      end else if (cnt_q != W'(HOLD)) begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_done <= 1'b0;
    end else begin
      hold_done <= active_q && (cnt_q == W'(HOLD));
    end
  end

endmodule : pin_low_counter

// *** rtl/debug_mode_entry_control.sv ***
// debug mode entry and behaviour control for the processor core
// Function
// - in debug mode fetch stops; only debugger-directed instructions execute
// - system clock keeps running in debug mode unless stop mode
// - enabled peripherals keep running in debug mode unless stop mode
// - entering debug mode leaves halt mode automatically
// - watchdog refreshed every cycle in debug mode when enabled
// - executing the breakpoint instruction enters debug mode
// - debug pin low in first cycle after reset release enters debug mode at once
`timescale 1ns/100ps
module debug_mode_entry_control #(
  parameter bit          LARGE_PACKAGE = 1'b1,
  parameter int unsigned HOLD_CYCLES   = debug_mode_pkg::PIN_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // debug pin (input side only)
  input  wire logic debug_pin_i,
  // core status
  input  wire logic breakpoint_executed,
  input  wire logic halt_mode_i,
  input  wire logic stop_mode_i,
  input  wire logic wdt_enable_i,
  // debugger commands
  input  wire logic debugger_exec_req,
  input  wire logic debugger_exit_req,
  // controls to the core
  output logic      debug_mode,
  output logic      fetch_enable,
  output logic      exec_directed,
  output logic      halt_exit,
  output logic      sys_clk_enable,
  output logic      periph_enable,
  output logic      wdt_refresh,
  output logic      pin_hold_met
);

  debug_mode_pkg::mode_t state_q;
  debug_mode_pkg::mode_t state_d;
  logic                  rst_q;
  logic                  strap_entry;
  logic                  arm_hold;
  logic                  in_debug_d;

  // reset release is seen one cycle after rst falls
  always_ff @(posedge clk_sys) begin
    rst_q <= rst;
  end

  // pin sampled on first cycle after reset release
  assign strap_entry = LARGE_PACKAGE && rst_q && !rst && !debug_pin_i;
  assign arm_hold    = strap_entry;

  always_comb begin
    state_d = state_q;
    case (state_q)
      debug_mode_pkg::MODE_RUN: begin
        if (strap_entry || breakpoint_executed) begin
          state_d = debug_mode_pkg::MODE_DEBUG;
        end
      end
      debug_mode_pkg::MODE_DEBUG: begin
        if (debugger_exit_req) begin
          state_d = debug_mode_pkg::MODE_EXIT;
        end
      end
      debug_mode_pkg::MODE_EXIT: begin
        state_d = debug_mode_pkg::MODE_RUN;
      end
      default: begin
        state_d = debug_mode_pkg::MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= debug_mode_pkg::mode_t'(debug_mode_pkg::MODE_RESET);
    end else begin
      state_q <= state_d;
    end
  end

  // core controls registered from next state
  assign in_debug_d = (state_d == debug_mode_pkg::MODE_DEBUG);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      debug_mode <= 1'b0;
    end else begin
      debug_mode <= in_debug_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_enable <= 1'b0;
    end else begin
      fetch_enable <= !in_debug_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exec_directed <= 1'b0;
    end else begin
      exec_directed <= in_debug_d && debugger_exec_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      halt_exit <= 1'b0;
    end else begin
      halt_exit <= in_debug_d && halt_mode_i;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdt_refresh <= 1'b0;
    end else begin
      wdt_refresh <= in_debug_d && wdt_enable_i;
    end
  end

  // clock and peripherals gated only by stop mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_clk_enable <= 1'b1;
    end else begin
      sys_clk_enable <= !stop_mode_i;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      periph_enable <= 1'b1;
    end else begin
      periph_enable <= !stop_mode_i;
    end
  end

  // observe that the host kept the pin low long enough
  pin_low_counter #(
    .HOLD (HOLD_CYCLES),
    .W    (debug_mode_pkg::HOLD_CNT_W)
  ) u_hold (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .debug_pin_i (debug_pin_i),
    .arm         (arm_hold),
    .hold_done   (pin_hold_met)
  );

endmodule : debug_mode_entry_control

// *** testbench/debug_mode_assertions.sv ***
// checker: debug mode entry control port assertions
`timescale 1ns/100ps
module debug_mode_assertions (
  input wire logic clk_sys, rst, debug_pin_i, breakpoint_executed,
  input wire logic halt_mode_i, stop_mode_i, wdt_enable_i, debugger_exit_req,
  input wire logic debugger_exec_req, exec_directed,
  input wire logic debug_mode, fetch_enable, halt_exit, sys_clk_enable,
  input wire logic periph_enable, wdt_refresh
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_exit;
    debug_mode && debugger_exit_req;
  endsequence
  a_fetch_idle: assert property (debug_mode |-> !fetch_enable)
    else $error("fetch in debug");
  a_clock_runs:
    assert property (1 |=> sys_clk_enable != $past(stop_mode_i))
    else $error("clock vs stop");
  a_periph_runs:
    assert property (1 |=> periph_enable != $past(stop_mode_i))
    else $error("periph vs stop");
  a_halt_left:
    assert property (debug_mode && halt_mode_i && !debugger_exit_req
      |=> halt_exit) else $error("halt kept");
  a_exec_directed:
    assert property (debug_mode && debugger_exec_req && !debugger_exit_req
      |=> exec_directed) else $error("no directed exec");
  a_wdt_fresh:
    assert property (debug_mode && wdt_enable_i && !debugger_exit_req
      |=> wdt_refresh) else $error("no refresh");
  a_break_enters:
    assert property (breakpoint_executed && fetch_enable
      && !$past(debugger_exit_req) |=> debug_mode) else $error("no entry");
  a_strap_entry:
    assert property ($fell(rst) |=> debug_mode == !$past(debug_pin_i))
    else $error("strap");
  a_exit_resumes:
    assert property (s_exit |=> !debug_mode && fetch_enable)
    else $error("exit");
endmodule : debug_mode_assertions
bind debug_mode_entry_control debug_mode_assertions u_chk (.*);

// *** testbench/debug_host_model.sv ***
// host model: holds the debug pin low around reset when strapping
`timescale 1ns/100ps
module debug_host_model #(parameter int HOLD = 8) (
  input  wire logic clk_sys, rst, strap,
  output wire logic pin
);
  int n;
  always_ff @(posedge clk_sys) n <= rst ? 0 : n + 1;
  assign pin = !(strap && n <= HOLD);
endmodule : debug_host_model

// *** testbench/debug_mode_entry_control_tb.sv ***
// testbench: debug mode entry control scenarios
`timescale 1ns/100ps
module debug_mode_entry_control_tb;
  logic       clk_sys = 0, rst = 1, strap = 1, halt_mode_i = 0;
  logic       stop_mode_i = 0, wdt_enable_i = 0, debug_pin_i;
  logic [2:0] req = 3'h0;
  wire logic  debugger_exit_req = req[2], debugger_exec_req = req[1];
  wire logic  breakpoint_executed = req[0];
  logic       debug_mode, fetch_enable, exec_directed, halt_exit;
  logic       sys_clk_enable, periph_enable, wdt_refresh, pin_hold_met;
  wire logic [6:0] outs = {debug_mode, fetch_enable, exec_directed,
    halt_exit, sys_clk_enable, periph_enable, wdt_refresh};
  int         bad_count = 0, check_count = 0;
  debug_host_model #(.HOLD(12)) u_host (.clk_sys, .rst, .strap,
    .pin(debug_pin_i));
  debug_mode_entry_control #(.HOLD_CYCLES(8)) u_dut (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task check(logic [6:0] seen, logic [6:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t outputs %h not %h", $time, seen, want);
    end
  endtask : check
  task drive(logic [2:0] a, logic [2:0] b);
    @(posedge clk_sys) req <= a;
    @(posedge clk_sys) req <= b;
    #1;
  endtask : drive
  task do_reset(logic s);
    @(posedge clk_sys) {rst, strap} <= {1'h1, s};
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    drive(3'h0, 3'h0);
  endtask : do_reset
  task t_strap;
    do_reset(1'h1);
    check(outs, 7'h46);
    check({6'h0, pin_hold_met}, 7'h00);
    drive(3'h2, 3'h0);
    check(outs, 7'h56);
    @(posedge clk_sys) {halt_mode_i, wdt_enable_i, stop_mode_i} <= 3'h7;
    drive(3'h0, 3'h0);
    check(outs, 7'h49);
    @(posedge clk_sys) stop_mode_i <= 1'h0;
    drive(3'h4, 3'h1);
    drive(3'h0, 3'h0);
    check(outs, 7'h26);
    check({6'h0, pin_hold_met}, 7'h01);
  endtask : t_strap
  task t_break;
    do_reset(1'h0);
    check(outs, 7'h26);
    drive(3'h1, 3'h0);
    check(outs, 7'h4F);
    drive(3'h1, 3'h0);
    check(outs, 7'h4F);
    drive(3'h4, 3'h0);
    drive(3'h1, 3'h0);
    check(outs, 7'h4F);
  endtask : t_break
  task give_verdict;
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    t_strap();
    t_break();
    give_verdict();
  end
  initial begin
    #2000;
    bad_count++;
    give_verdict();
  end
endmodule : debug_mode_entry_control_tb
